// ===== rtl/rwm_reset_ctrl.v
// Reset sequencer with software watchdog and clock-loss monitor
`timescale 1ns/10ps
`include "rwm_defs.vh"
module rwm_reset_ctrl
#(
	parameter POR_CYCLES = 4064
)
(
	// Clock and power-on reset
	input wire I_MCLK,
	input wire I_RST_B,
	// Reset pin, open drain
	input wire I_RESET_PIN_IN,
	output wire O_RESET_PIN_OUT,
	output wire O_RESET_PIN_OE,
	// Operating mode and configuration
	input wire I_SPECIAL_MODE,
	input wire I_WATCHDOG_DISABLE_CFG,
	// Watchdog rate select write
	input wire I_RATE_WR,
	input wire [1:0] I_WATCHDOG_RATE_SEL,
	// Watchdog service register write
	input wire I_SERVICE_WR,
	input wire [7:0] I_SERVICE_DATA,
	// Disable-resets bit write (special modes)
	input wire I_DISABLE_RESETS_WR,
	input wire I_DISABLE_RESETS_DATA,
	// Clock monitor enable write and RC-delay timeout
	input wire I_CLOCK_LOSS_EN_WR,
	input wire I_CLOCK_LOSS_EN_DATA,
	input wire I_CLK_LOSS_TIMEOUT,
	// Status and core reset
	output reg O_CORE_RST,
	output reg [15:0] O_RESET_VECTOR,
	output reg [1:0] O_RESET_CAUSE,
	output reg [1:0] O_RATE_SEL,
	output reg O_CLOCK_LOSS_DETECT_EN,
	output reg O_DISABLE_RESETS_BIT,
	output reg O_WATCHDOG_EN
);

	// One-hot sequencer states
	localparam ST_POR = 4'h1;
	localparam ST_DRIVE = 4'h2;
	localparam ST_WAIT = 4'h4;
	localparam ST_RUN = 4'h8;

	// Terminal counts; the sample wait adds three cycles of pin-filter lag
	// Power-on count limited to 4096 by the counter width
	localparam [31:0] POR_LAST = POR_CYCLES - 1;
	localparam [2:0] DRIVE_LAST = `RWM_PIN_DRIVE_CYCLES - 3'h1;
	localparam [2:0] SAMPLE_LAST = `RWM_PIN_SAMPLE_DELAY + 3'h3;

	reg rst_s1_reg;
	reg rst_s2_reg;
	wire rst_n = rst_s2_reg;

	always @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	// Pin synchroniser: first stage read only by second
	reg pin_s1_reg;
	reg pin_s2_reg;
	reg pin_s3_reg;
	reg pin_level_reg;
	always @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			pin_s3_reg <= 1'b1;
			pin_level_reg <= 1'b1;
		end
		else
		begin
			pin_s1_reg <= I_RESET_PIN_IN;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			if (pin_s2_reg == pin_s3_reg)
				pin_level_reg <= pin_s3_reg;
		end
	end

	// RC timeout is asynchronous; it is produced without this clock
	reg clk_s1_reg;
	reg clk_s2_reg;
	reg clk_s3_reg;
	always @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
			clk_s3_reg <= 1'b0;
		end
		else
		begin
			clk_s1_reg <= I_CLK_LOSS_TIMEOUT;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
		end
	end
	wire clk_loss = clk_s2_reg & clk_s3_reg; // see R15 R16

	reg [3:0] state_reg;
	reg [11:0] por_cnt_reg;
	reg [2:0] seq_cnt_reg;
	reg [6:0] win_cnt_reg;
	reg rate_locked_reg;
	reg armed_reg;
	// Top bit is the slowest tap, so every rate code reaches its timeout
	reg [`RWM_PRESCALE_BITS+6:0] wdg_cnt_reg;
	reg [1:0] pend_cause_reg;
	reg internal_req_reg;

	// Special modes fetch from the mirrored page below the normal vectors
	function [15:0] vec_of;
		input [1:0] cause;
		input special;
		reg [15:0] v;
		begin
			case (cause)
				`RWM_CAUSE_CLK: v = `RWM_VEC_CLK;
				`RWM_CAUSE_WDG: v = `RWM_VEC_WDG;
				default: v = `RWM_VEC_EXT;
			endcase
			vec_of = special ? (v & `RWM_VEC_SPECIAL_MASK) : v;
		end
	endfunction

	// Watchdog timeout bit per rate code
	reg wdg_timeout;
	always @*
	begin
		case (O_RATE_SEL) // see R10
			2'h0: wdg_timeout = wdg_cnt_reg[`RWM_PRESCALE_BITS];
			2'h1: wdg_timeout = wdg_cnt_reg[`RWM_PRESCALE_BITS+2];
			2'h2: wdg_timeout = wdg_cnt_reg[`RWM_PRESCALE_BITS+4];
			default: wdg_timeout = wdg_cnt_reg[`RWM_PRESCALE_BITS+6];
		endcase
	end

	wire running = state_reg == ST_RUN;
	wire service_ok = I_SERVICE_WR && I_SERVICE_DATA == `RWM_CLEAR_CODE && armed_reg; // see R12
	wire wdg_fire = running && O_WATCHDOG_EN && !O_DISABLE_RESETS_BIT && wdg_timeout; // see R7
	wire clk_fire = running && O_CLOCK_LOSS_DETECT_EN && clk_loss; // see R14, R17
	wire ext_fire = running && !pin_level_reg;

	// Normal modes take one rate write inside the window; special modes any time
	wire rate_wr_ok = I_RATE_WR && (I_SPECIAL_MODE || (!rate_locked_reg && win_cnt_reg != `RWM_RATE_WINDOW));
	wire arm_wr = I_SERVICE_WR && I_SERVICE_DATA == `RWM_ARM_CODE; // see R12

	// Clock loss outranks the watchdog when both strike together
	reg [1:0] fire_cause;
	always @*
	begin
		if (clk_fire)
			fire_cause = `RWM_CAUSE_CLK;
		else if (wdg_fire)
			fire_cause = `RWM_CAUSE_WDG;
		else
			fire_cause = `RWM_CAUSE_EXT;
	end

	// Open drain: the pin is only ever pulled low, never driven high
	assign O_RESET_PIN_OUT = 1'b0;
	assign O_RESET_PIN_OE = state_reg == ST_DRIVE; // see R3

	always @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_POR;
			por_cnt_reg <= 12'h000;
			seq_cnt_reg <= 3'h0;
			win_cnt_reg <= 7'h00;
			rate_locked_reg <= 1'b0;
			armed_reg <= 1'b0;
			wdg_cnt_reg <= {(`RWM_PRESCALE_BITS+7){1'b0}};
			pend_cause_reg <= `RWM_CAUSE_EXT;
			internal_req_reg <= 1'b0;
			O_CORE_RST <= 1'b1;
			O_RESET_VECTOR <= `RWM_VEC_EXT;
			O_RESET_CAUSE <= `RWM_CAUSE_EXT;
			O_RATE_SEL <= 2'h0;
			O_CLOCK_LOSS_DETECT_EN <= 1'b0;
			O_DISABLE_RESETS_BIT <= 1'b0;
			O_WATCHDOG_EN <= 1'b0;
		end
		else
		begin
			case (state_reg)
				// Pin may be low already; the sample stage decides what follows
				ST_POR:
				begin
					if ({20'h00000, por_cnt_reg} != POR_LAST) // see R1
						por_cnt_reg <= por_cnt_reg + 12'h001;
					else
					begin
						state_reg <= ST_DRIVE;
						seq_cnt_reg <= 3'h0;
						pend_cause_reg <= `RWM_CAUSE_EXT;
						internal_req_reg <= 1'b0;
					end
				end

				// Pin pulled low for a fixed count, whatever the cause
				ST_DRIVE:
				begin
					if (seq_cnt_reg != DRIVE_LAST)
						seq_cnt_reg <= seq_cnt_reg + 3'h1;
					else
					begin
						seq_cnt_reg <= 3'h0;
						state_reg <= ST_WAIT;
					end
				end

				ST_WAIT:
				begin
					// Pin sync lag is covered by the extra settle cycles
					if (seq_cnt_reg != SAMPLE_LAST)
						seq_cnt_reg <= seq_cnt_reg + 3'h1;
					else if (pin_level_reg) // see R2, R4
					begin
						state_reg <= ST_RUN;
						O_CORE_RST <= 1'b0;
						O_RESET_CAUSE <= internal_req_reg ? pend_cause_reg : `RWM_CAUSE_EXT;
						O_RESET_VECTOR <= vec_of(internal_req_reg ? pend_cause_reg : `RWM_CAUSE_EXT,
							I_SPECIAL_MODE); // see R5
						O_WATCHDOG_EN <= !I_WATCHDOG_DISABLE_CFG; // see R8
						O_DISABLE_RESETS_BIT <= I_SPECIAL_MODE; // see R9
						O_RATE_SEL <= 2'h0; // see R11
						O_CLOCK_LOSS_DETECT_EN <= 1'b0; // see R19
						rate_locked_reg <= 1'b0;
						win_cnt_reg <= 7'h00;
						armed_reg <= 1'b0;
						wdg_cnt_reg <= {(`RWM_PRESCALE_BITS+7){1'b0}};
					end
					else
						// Pin still held low from outside: the cause becomes external
						internal_req_reg <= 1'b0;
				end

				ST_RUN:
				begin
					// Window count stops at its end so late rate writes stay refused
					if (win_cnt_reg != `RWM_RATE_WINDOW)
						win_cnt_reg <= win_cnt_reg + 7'h01;

					if (rate_wr_ok)
					begin
						O_RATE_SEL <= I_WATCHDOG_RATE_SEL; // see R11
						rate_locked_reg <= 1'b1;
					end

					if (I_DISABLE_RESETS_WR && I_SPECIAL_MODE)
						O_DISABLE_RESETS_BIT <= I_DISABLE_RESETS_DATA; // see R9

					if (I_CLOCK_LOSS_EN_WR)
						O_CLOCK_LOSS_DETECT_EN <= I_CLOCK_LOSS_EN_DATA; // see R14

					// A clear outranks counting and leaves the mechanism disarmed
					if (service_ok)
					begin
						wdg_cnt_reg <= {(`RWM_PRESCALE_BITS+7){1'b0}}; // see R20
						armed_reg <= 1'b0;
					end
					else
					begin
						wdg_cnt_reg <= wdg_cnt_reg + 1'b1; // see R21
						if (arm_wr)
							armed_reg <= 1'b1; // see R13
					end

					if (clk_fire || wdg_fire || ext_fire) // see R6
					begin
						state_reg <= ST_DRIVE;
						seq_cnt_reg <= 3'h0;
						O_CORE_RST <= 1'b1;
						// Cleared at once so no stale setting survives the sequence
						O_CLOCK_LOSS_DETECT_EN <= 1'b0; // see R19
						O_RATE_SEL <= 2'h0; // see R11
						internal_req_reg <= clk_fire | wdg_fire;
						pend_cause_reg <= fire_cause; // see R5
					end
				end

				default:
					state_reg <= ST_POR;
			endcase
		end
	end

endmodule

// ===== rtl/rwm_defs.vh
// Constants for the reset, watchdog and clock-loss monitor block
// Notes on behaviour
// R1: After power-on, hold reset for 4064 clock cycles so the clock generator settles.
// R2: If reset pin still low after that count, stay in reset until it rises.
// R3: On any reset condition drive the reset pin low four cycles, then release.
// R4: Sample pin two cycles after release; low means external, high means internal.
// R5: Power-on and pin resets share one vector; watchdog and clock loss own one each.
// R6: Reset aborts execution, forces start address, initialises registers and control bits.
// R7: Enabled watchdog runs freely; missing service before timeout starts a system reset.
// R8: Watchdog enable follows disable config bit, latched only at a following reset.
// R9: In special modes watchdog resets start inhibited; writing disable bit 0 enables them.
// R10: Watchdog clock is bus clock over 2^15, then over 1, 4, 16 or 64.
// R11: Reset clears rate field; normal modes allow one write within 64 cycles.
// R12: Write 55h to arm, then AAh; only that ordered pair clears the watchdog.
// R13: Other writes may come between arming and clearing without harm.
// R14: With monitor enabled, no clock edge within the RC delay issues a reset.
// R15: Clock monitor works from its RC delay without any device clock.
// R16: Below 10 kHz is a failure; 200 kHz or more never is.
// R17: Stopping clocks with the monitor enabled produces a reset sequence.
// R18: Software clears monitor enable before stop and sets it again afterwards.
// R19: Every reset clears the clock monitor enable bit.
// R20: Completed service restarts the count from zero and disarms clearing.
// R21: Service writes of other values never clear the watchdog count.
`ifndef RWM_DEFS_VH
`define RWM_DEFS_VH
`define RWM_POR_CYCLES 12'hFE0
`define RWM_PIN_DRIVE_CYCLES 3'h4
`define RWM_PIN_SAMPLE_DELAY 3'h2
`define RWM_RATE_WINDOW 7'h40
`define RWM_PRESCALE_BITS 15
`define RWM_ARM_CODE 8'h55
`define RWM_CLEAR_CODE 8'hAA
`define RWM_CAUSE_EXT 2'h0
`define RWM_CAUSE_CLK 2'h1
`define RWM_CAUSE_WDG 2'h2
`define RWM_VEC_EXT 16'hFFFE
`define RWM_VEC_CLK 16'hFFFC
`define RWM_VEC_WDG 16'hFFFA
`define RWM_VEC_SPECIAL_MASK 16'hBFFF
`endif

// ===== verification/rwm_partner.sv
// External reset circuit: pull-up on the reset wire plus a holding switch
`timescale 1ns/10ps
module rwm_partner (
	// Device side
	input wire i_oe,
	input wire i_pin_out,
	// Holding switch from the bench
	input wire i_hold_low,
	// Resolved wire level
	output wire o_pin
);
	// Pull-up wins only when nobody pulls low
	assign o_pin = ((i_oe && !i_pin_out) || i_hold_low) ? 1'b0 : 1'b1;
endmodule

// ===== verification/rwm_reset_ctrl_checker.sv
// Port assertions for the reset sequencer
`timescale 1ns/10ps
module rwm_reset_ctrl_checker (
	// Clock, reset and monitor input
	input wire I_MCLK,
	input wire I_RST_B,
	input wire I_CLK_LOSS_TIMEOUT,
	// Watched outputs
	input wire O_RESET_PIN_OUT,
	input wire O_RESET_PIN_OE,
	input wire O_CORE_RST,
	input wire [1:0] O_RATE_SEL,
	input wire O_CLOCK_LOSS_DETECT_EN,
	input wire O_WATCHDOG_EN
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	pin_never_high_a: assert property (!O_RESET_PIN_OUT) else $error("pin driven high");
	drive_four_a: assert property ($rose(O_RESET_PIN_OE) |-> O_RESET_PIN_OE[*4] ##1 !O_RESET_PIN_OE)
		else $error("pin drive length wrong");
	sample_wait_a: assert property ($fell(O_RESET_PIN_OE) |-> O_CORE_RST[*2]) else $error("released early");
	drive_in_reset_a: assert property (O_RESET_PIN_OE |-> O_CORE_RST) else $error("pin driven out of reset");
	monitor_cleared_a: assert property (O_CORE_RST && $past(O_CORE_RST) |-> !O_CLOCK_LOSS_DETECT_EN)
		else $error("monitor enable kept");
	rate_cleared_a: assert property (O_CORE_RST && $past(O_CORE_RST) |-> O_RATE_SEL == 2'h0)
		else $error("rate kept in reset");
	clock_loss_a: assert property ((O_CLOCK_LOSS_DETECT_EN && I_CLK_LOSS_TIMEOUT)[*3] |-> ##[0:3] O_CORE_RST)
		else $error("clock loss ignored");
	enable_held_a: assert property (!O_CORE_RST && $past(!O_CORE_RST) |-> $stable(O_WATCHDOG_EN))
		else $error("watchdog enable moved");
endmodule
bind rwm_reset_ctrl rwm_reset_ctrl_checker u_chk (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
	.I_CLK_LOSS_TIMEOUT(I_CLK_LOSS_TIMEOUT), .O_RESET_PIN_OUT(O_RESET_PIN_OUT), .O_RESET_PIN_OE(O_RESET_PIN_OE),
	.O_CORE_RST(O_CORE_RST), .O_RATE_SEL(O_RATE_SEL), .O_CLOCK_LOSS_DETECT_EN(O_CLOCK_LOSS_DETECT_EN),
	.O_WATCHDOG_EN(O_WATCHDOG_EN));

// ===== verification/rwm_reset_ctrl_tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
module rwm_reset_ctrl_tb_top;
	logic clk = 0, rst_b = 0, hold = 1, cfg = 0, clt = 0, rwr = 0, swr = 0, dwr = 0, cwr = 0, spec = 0;
	logic [1:0] rate = 0, code, cause, rsel;
	logic [7:0] sdata = 0;
	logic [15:0] vec;
	logic [31:0] seed = 32'h252C;
	wire pin, oe, pout, core, mon_en, dis_rst, wen;
	int checked = 0, n_mismatch = 0, cyc = 0;
	rwm_partner u_far (.i_oe(oe), .i_pin_out(pout), .i_hold_low(hold), .o_pin(pin));
	rwm_reset_ctrl #(.POR_CYCLES(8)) u_dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_RESET_PIN_IN(pin),
		.O_RESET_PIN_OUT(pout), .O_RESET_PIN_OE(oe), .I_SPECIAL_MODE(spec), .I_WATCHDOG_DISABLE_CFG(cfg),
		.I_RATE_WR(rwr), .I_WATCHDOG_RATE_SEL(rate), .I_SERVICE_WR(swr), .I_SERVICE_DATA(sdata),
		.I_DISABLE_RESETS_WR(dwr), .I_DISABLE_RESETS_DATA(sdata[0]), .I_CLOCK_LOSS_EN_WR(cwr),
		.I_CLOCK_LOSS_EN_DATA(sdata[0]), .I_CLK_LOSS_TIMEOUT(clt), .O_CORE_RST(core), .O_RESET_VECTOR(vec),
		.O_RESET_CAUSE(cause), .O_RATE_SEL(rsel), .O_CLOCK_LOSS_DETECT_EN(mon_en), .O_DISABLE_RESETS_BIT(dis_rst),
		.O_WATCHDOG_EN(wen));
	always #12.5 clk = ~clk;
	function logic [7:0] junk();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		junk = (seed[7:0] == 8'h55 || seed[7:0] == 8'hAA) ? 8'h00 : seed[7:0];
	endfunction
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wait_core(input logic v, input int lim);
		int k;
		k = 0;
		while (core !== v && k < lim)
		begin
			@(negedge clk);
			k++;
		end
		chk("core_rst", v, core);
	endtask
	// One-cycle strobe: 0 rate, 1 service, 2 monitor enable, 3 disable-resets
	task pulse(input int w, input logic [7:0] d);
		sdata = d;
		rate = d[1:0];
		{rwr, swr, cwr, dwr} = {w == 0, w == 1, w == 2, w == 3};
		@(negedge clk);
		{rwr, swr, cwr, dwr} = 4'h0;
		@(negedge clk);
	endtask
	task give_verdict;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 60000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (8) @(negedge clk);
		rst_b = 1;
		// Pin held low past the power-on count
		repeat (30) @(negedge clk);
		chk("core_held", 1, core);
		hold = 0;
		wait_core(0, 20);
		chk("cause", 0, cause);
		chk("vector", 16'hFFFE, vec);
		chk("mon_en", 0, mon_en);
		chk("wdg_en", 1, wen);
		sdata = junk();
		code = sdata[1:0];
		pulse(0, {6'h0, code});
		chk("rate", code, rsel);
		pulse(0, {6'h0, ~code});
		chk("rate_once", code, rsel);
		pulse(3, 8'h00);
		chk("dis_rst", 0, dis_rst);
		pulse(2, 8'h01);
		chk("mon_en_set", 1, mon_en);
		// Clocks stopped with the monitor still on, as a deliberate reset
		clt = 1;
		wait_core(1, 8);
		clt = 0;
		wait_core(0, 30);
		chk("cause", 1, cause);
		chk("vector", 16'hFFFC, vec);
		chk("rate", 0, rsel);
		chk("mon_en", 0, mon_en);
		repeat (20000) @(negedge clk);
		pulse(1, 8'h55);
		pulse(1, junk());
		pulse(1, 8'hAA);
		cfg = 1;
		repeat (20000) @(negedge clk);
		chk("no_timeout", 0, core);
		chk("wdg_en", 1, wen);
		pulse(1, 8'hAA);
		pulse(1, junk());
		wait_core(1, 13500);
		wait_core(0, 30);
		chk("cause", 2, cause);
		chk("vector", 16'hFFFA, vec);
		chk("wdg_en", 0, wen);
		// Special mode: pin held low from outside while running
		spec = 1;
		hold = 1;
		wait_core(1, 10);
		hold = 0;
		wait_core(0, 40);
		chk("cause", 0, cause);
		chk("vector", 16'hBFFE, vec);
		chk("dis_rst", 1, dis_rst);
		pulse(3, 8'h00);
		chk("dis_rst", 0, dis_rst);
		pulse(0, 8'h03);
		pulse(0, 8'h02);
		chk("rate_special", 2, rsel);
		give_verdict;
	end
endmodule
